// [rtl/apc_pkg.sv]
package apc_pkg;

   // -------------------------------------------------------------------------
   // Register map (indices; byte address is four times the index)
   // -------------------------------------------------------------------------
   localparam int          IDX_W        = 16;
   localparam int          ADDR_W       = IDX_W + 2;
   localparam logic [15:0] IDX_ACC      = 16'h1d16;
   localparam logic [15:0] IDX_PREV     = 16'h1d1b;
   localparam logic [15:0] IDX_CTRL     = 16'h1d30;
   localparam logic [15:0] IDX_PREV_HI  = 16'h1d31;
   localparam logic [15:0] IDX_PREV_LO  = 16'h1d32;
   localparam logic [15:0] IDX_FILTER   = 16'h1d33;
   localparam logic [15:0] IDX_SAMPLE   = 16'h1d34;

   // -------------------------------------------------------------------------
   // Widths, fields and reset values
   // -------------------------------------------------------------------------
   localparam int          DATA_W       = 32;
   localparam int          ACC_W        = 18;
   localparam int          ACC_REG_W    = 24;
   localparam int          VAL_W        = 16;
   localparam int          RAW_W        = 12;
   localparam int          SHIFT_W      = 3;
   localparam int          CTRL_PREVIOUS_SOURCE_SELECT    = 0;
   localparam int          CTRL_FMT     = 1;
   localparam int          CTRL_LPF     = 2;
   localparam int          CTRL_SHIFT   = 4;
   localparam logic [15:0] PREV_RST     = 16'h0000;
   localparam logic [15:0] SAMPLE_RST   = 16'h0000;
   localparam logic [17:0] ACC_RST      = 18'h00000;
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // -------------------------------------------------------------------------
   // AXI4-Lite carriers
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } apc_axil_req_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } apc_axil_rsp_t;

endpackage : apc_pkg

// [rtl/apc_capture.sv]
// Function
// - Previous-value register is 16 bits, read only, zero after reset.
// - Source select set: capture filter output at conversion start.
// - Source select clear: capture sample result at conversion start.
// - Captured sample result carries the same format as the sample result.
// - High and low byte aliases return bits 15:8 and 7:0.
// - Accumulator is signed; bits 23:18 read as sign copies, bits 31:24 read as zero.
// - Filter output is accumulator shifted right, or low-pass output in that mode.
`timescale 1ns/100ps
`default_nettype none

module apc_capture
   import apc_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 nrst,
   // Converter side, same clock
   input  wire logic                 conv_start,
   input  wire logic                 conv_done,
   input  wire logic [RAW_W-1:0]     conv_raw,
   input  wire logic [VAL_W-1:0]     lpf_value,
   // Register bus
   input  wire apc_axil_req_t        axil_req,
   output apc_axil_rsp_t             axil_rsp,
   // Observed state
   output logic      [VAL_W-1:0]     filter_output_value,
   output logic      [VAL_W-1:0]     previous_conversion_value
);

   // ------------------------------------------------------------------------
   // Local constants
   // ------------------------------------------------------------------------
   localparam int LANE_W   = 8;
   localparam int LANES    = DATA_W / LANE_W;
   localparam int CTRL_W   = 8;
   // Byte alias split points of the previous value
   localparam int PREV_TOP = VAL_W - 1;
   localparam int PREV_MID = LANE_W;
   localparam int PREV_BOT = LANE_W - 1;

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------
   function automatic logic [DATA_W-1:0] byte_merge(input logic [DATA_W-1:0] old_v,
                                                    input logic [DATA_W-1:0] new_v,
                                                    input logic [LANES-1:0]  strb);
      logic [DATA_W-1:0] res;
      res = old_v;
      for (int i = 0; i < LANES; i++) begin
         if (strb[i]) begin
            res[i*LANE_W +: LANE_W] = new_v[i*LANE_W +: LANE_W];
         end
      end
      return res;
   endfunction : byte_merge

   function automatic logic [IDX_W-1:0] addr_idx(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:2];
   endfunction : addr_idx

   // ------------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------------
   logic [VAL_W-1:0]  prev_ff;
   logic [VAL_W-1:0]  sample_ff;
   logic [ACC_W-1:0]  acc_ff;
   logic [CTRL_W-1:0] ctrl_ff;
   logic              aw_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic              w_ff;
   logic [DATA_W-1:0] wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              rvalid_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [1:0]        rresp_ff;

   // ------------------------------------------------------------------------
   // Control fields and data path
   // ------------------------------------------------------------------------
   wire logic               previous_source_select  = ctrl_ff[CTRL_PREVIOUS_SOURCE_SELECT];
   wire logic               result_format_select    = ctrl_ff[CTRL_FMT];
   wire logic               lowpass_mode            = ctrl_ff[CTRL_LPF];
   wire logic [SHIFT_W-1:0] accumulator_shift_count = ctrl_ff[CTRL_SHIFT +: SHIFT_W];

   // Format set: right justified; clear: left justified
   wire logic [VAL_W-1:0] formatted_raw = result_format_select
                                          ? {{(VAL_W-RAW_W){1'b0}}, conv_raw}
                                          : {conv_raw, {(VAL_W-RAW_W){1'b0}}};
   wire logic [ACC_W-1:0] acc_shifted   = ACC_W'($signed(acc_ff) >>> accumulator_shift_count);
   wire logic [VAL_W-1:0] filt_value    = lowpass_mode ? lpf_value
                                                       : acc_shifted[VAL_W-1:0];
   // Sample result is already formatted, so the copy keeps its format
   wire logic [VAL_W-1:0] nxt_prev      = previous_source_select ? filt_value
                                                                 : sample_ff;
   wire logic [ACC_W-1:0] acc_summed    = acc_ff + ACC_W'(conv_raw);
   wire logic [ACC_REG_W-1:0] acc_ext   = {{(ACC_REG_W-ACC_W){acc_ff[ACC_W-1]}}, acc_ff};

   // ------------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------------
   wire logic             wr_go     = aw_ff && w_ff && !bvalid_ff;
   wire logic [IDX_W-1:0] wr_idx    = addr_idx(awaddr_ff);
   wire logic             wr_acc    = wr_go && (wr_idx == IDX_ACC);
   wire logic             wr_ctrl   = wr_go && (wr_idx == IDX_CTRL);
   wire logic             wr_ro     = (wr_idx == IDX_PREV) || (wr_idx == IDX_PREV_HI)
                                      || (wr_idx == IDX_PREV_LO) || (wr_idx == IDX_FILTER)
                                      || (wr_idx == IDX_SAMPLE);
   wire logic             wr_mapped = (wr_idx == IDX_ACC) || (wr_idx == IDX_CTRL) || wr_ro;
   wire logic             rd_go     = axil_req.arvalid && !rvalid_ff;
   wire logic [IDX_W-1:0] rd_idx    = addr_idx(axil_req.araddr);
   // Partial strobes keep the untouched bytes of the live register
   wire logic [DATA_W-1:0] wr_merged_acc  = byte_merge(DATA_W'(acc_ext), wdata_ff, wstrb_ff);
   wire logic [DATA_W-1:0] wr_merged_ctrl = byte_merge(DATA_W'(ctrl_ff), wdata_ff, wstrb_ff);

   logic [DATA_W-1:0] rd_mux;
   logic              rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      unique case (rd_idx)
         IDX_ACC:     rd_mux = DATA_W'(acc_ext);
         IDX_PREV:    rd_mux = DATA_W'(prev_ff);
         IDX_PREV_HI: rd_mux = DATA_W'(prev_ff[PREV_TOP:PREV_MID]);
         IDX_PREV_LO: rd_mux = DATA_W'(prev_ff[PREV_BOT:0]);
         IDX_CTRL:    rd_mux = DATA_W'(ctrl_ff);
         IDX_FILTER:  rd_mux = DATA_W'(filt_value);
         IDX_SAMPLE:  rd_mux = DATA_W'(sample_ff);
         default: begin
            rd_mux = '0;
            rd_hit = 1'b0;
         end
      endcase
   end

   assign axil_rsp.awready = !aw_ff && !bvalid_ff;
   assign axil_rsp.wready  = !w_ff && !bvalid_ff;
   assign axil_rsp.bvalid  = bvalid_ff;
   assign axil_rsp.bresp   = bresp_ff;
   assign axil_rsp.arready = !rvalid_ff;
   assign axil_rsp.rvalid  = rvalid_ff;
   assign axil_rsp.rdata   = rdata_ff;
   assign axil_rsp.rresp   = rresp_ff;

   // ------------------------------------------------------------------------
   // Handshake events
   // ------------------------------------------------------------------------
   // Ready is combinational, so a request is taken on its first valid edge
   wire logic       aw_take   = axil_req.awvalid && axil_rsp.awready;
   wire logic       w_take    = axil_req.wvalid && axil_rsp.wready;
   wire logic       b_done    = bvalid_ff && axil_req.bready;
   wire logic       r_done    = rvalid_ff && axil_req.rready;
   // Unmapped index answers with an error; read-only writes are dropped quietly
   wire logic [1:0] nxt_bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
   wire logic [1:0] nxt_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;

   // ------------------------------------------------------------------------
   // Next-state selection
   // ------------------------------------------------------------------------
   wire logic [CTRL_W-1:0] nxt_ctrl   = wr_ctrl ? wr_merged_ctrl[CTRL_W-1:0] : ctrl_ff;
   // Software write wins over a same-cycle accumulate; that sample is dropped
   wire logic              acc_load   = conv_done && !lowpass_mode;
   wire logic [ACC_W-1:0]  nxt_acc    = wr_acc   ? wr_merged_acc[ACC_W-1:0]
                                      : acc_load ? acc_summed
                                      :            acc_ff;
   wire logic [VAL_W-1:0]  nxt_sample = conv_done ? formatted_raw : sample_ff;

   // ------------------------------------------------------------------------
   // Write channel
   // ------------------------------------------------------------------------
   // Address stage; a take cannot meet an execute, the flag blocks ready
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         aw_ff     <= 1'b0;
         awaddr_ff <= '0;
      end else if (wr_go) begin
         aw_ff     <= 1'b0;
      end else if (aw_take) begin
         aw_ff     <= 1'b1;
         awaddr_ff <= axil_req.awaddr;
      end
   end

   // Data stage, independent of address order
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         w_ff     <= 1'b0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
      end else if (wr_go) begin
         w_ff     <= 1'b0;
      end else if (w_take) begin
         w_ff     <= 1'b1;
         wdata_ff <= axil_req.wdata;
         wstrb_ff <= axil_req.wstrb;
      end
   end

   // Response stands until the master takes it
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= nxt_bresp;
      end else if (b_done) begin
         bvalid_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rvalid_ff <= 1'b0;
      end else if (rd_go) begin
         rvalid_ff <= 1'b1;
      end else if (r_done) begin
         rvalid_ff <= 1'b0;
      end
   end

   // Data loads only on a take, so it stands until the handshake
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else if (rd_go) begin
         rdata_ff <= rd_mux;
         rresp_ff <= nxt_rresp;
      end
   end

   // ------------------------------------------------------------------------
   // Control, accumulator, sample result
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_ff <= CTRL_RST;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         acc_ff <= ACC_RST;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sample_ff <= SAMPLE_RST;
      end else begin
         sample_ff <= nxt_sample;
      end
   end

   // ------------------------------------------------------------------------
   // Previous-value capture
   // ------------------------------------------------------------------------
   // Whole word loads on one edge, so a read never sees a torn value
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prev_ff <= PREV_RST;
      end else if (conv_start) begin
         prev_ff <= nxt_prev;
      end
   end

   assign filter_output_value       = filt_value;
   assign previous_conversion_value = prev_ff;

endmodule : apc_capture

`default_nettype wire

// [tb/apc_capture_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module apc_capture_sva
   import apc_pkg::*;
(
   // Clock and reset
   input wire logic             clk_sys,
   input wire logic             nrst,
   // Converter side
   input wire logic             conv_start,
   input wire logic             conv_done,
   input wire logic [RAW_W-1:0] conv_raw,
   input wire logic [VAL_W-1:0] lpf_value,
   // Register bus
   input wire apc_axil_req_t    axil_req,
   input wire apc_axil_rsp_t    axil_rsp,
   // Observed state
   input wire logic [VAL_W-1:0] filter_output_value,
   input wire logic [VAL_W-1:0] previous_conversion_value
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   wire aw_go = axil_req.awvalid && axil_rsp.awready;
   wire w_go  = axil_req.wvalid && axil_rsp.wready;
   wire ar_go = axil_req.arvalid && axil_rsp.arready;
   prev_hold_a: assert property (!conv_start |=> $stable(previous_conversion_value))
      else $error("previous value changed without conversion start");
   prev_settle_a: assert property (conv_start ##1 !conv_start |=> $stable(previous_conversion_value))
      else $error("previous value still moving after capture");
   wr_answer_a: assert property (aw_go && w_go |=> !axil_rsp.bvalid ##1 axil_rsp.bvalid)
      else $error("write response not two edges after take");
   rd_answer_a: assert property (ar_go |=> axil_rsp.rvalid)
      else $error("read data not one edge after take");
   rd_clear_a: assert property (axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid)
      else $error("read data stayed after handshake");
   wr_clear_a: assert property (axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid)
      else $error("write response stayed after handshake");
   ar_block_a: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
      else $error("read address accepted while data pending");
   aw_block_a: assert property (axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready)
      else $error("write accepted while response pending");
   err_zero_a: assert property (axil_rsp.rvalid && axil_rsp.rresp == RESP_SLVERR
      |-> axil_rsp.rdata == 32'h0)
      else $error("refused read returned nonzero data");
   cover property (ar_go);
   cover property (aw_go && w_go);
   cover property (conv_start && conv_done);
endmodule : apc_capture_sva
bind apc_capture apc_capture_sva sva_u (.clk_sys(clk_sys), .nrst(nrst), .conv_start(conv_start),
   .conv_done(conv_done), .conv_raw(conv_raw), .lpf_value(lpf_value), .axil_req(axil_req),
   .axil_rsp(axil_rsp), .filter_output_value(filter_output_value),
   .previous_conversion_value(previous_conversion_value));
`default_nettype wire

// [tb/tb_adc_previous_result_capture.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_adc_previous_result_capture import apc_pkg::*; ;
   logic             clk_sys = 1'b0;
   logic             nrst = 1'b0;
   logic             conv_start = 1'b0;
   logic             conv_done = 1'b0;
   logic [RAW_W-1:0] conv_raw = '0;
   logic [VAL_W-1:0] lpf_value = '0;
   apc_axil_req_t    req = '0;
   apc_axil_rsp_t    rsp;
   logic [VAL_W-1:0] fltr;
   logic [VAL_W-1:0] prev;
   int               num_errors = 0;
   int               comparisons = 0;
   always #5 clk_sys = ~clk_sys;
   apc_capture dut_u (.clk_sys(clk_sys), .nrst(nrst), .conv_start(conv_start),
      .conv_done(conv_done), .conv_raw(conv_raw), .lpf_value(lpf_value), .axil_req(req),
      .axil_rsp(rsp), .filter_output_value(fltr), .previous_conversion_value(prev));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Response valid folded into the check, so a hung bus shows as a mismatch
   task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      req.awaddr <= {idx, 2'b00};
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1 && n < 50);
      chk({29'h0, rsp.bvalid, rsp.bresp}, {29'h0, 1'b1, er});
   endtask : wr
   task automatic rd(input logic [15:0] idx, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      req.araddr <= {idx, 2'b00};
      req.arvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1 && n < 50);
      chk({29'h0, rsp.rvalid, rsp.rresp}, {29'h0, 1'b1, er});
      chk(rsp.rdata, ed);
   endtask : rd
   task automatic conv(input logic s, input logic d, input logic [RAW_W-1:0] r);
      conv_start <= s;
      conv_done <= d;
      conv_raw <= r;
      @(posedge clk_sys);
      conv_start <= 1'b0;
      conv_done <= 1'b0;
      @(posedge clk_sys);
   endtask : conv
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict
   initial begin
      #100000;
      num_errors++;
      print_verdict();
   end
   initial begin
      req.bready <= 1'b1;
      req.rready <= 1'b1;
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      rd(IDX_PREV, {16'h0, PREV_RST}, RESP_OKAY);
      wr(IDX_PREV, 32'hffff, RESP_OKAY);
      rd(IDX_PREV, 32'h0, RESP_OKAY);
      rd(16'h0001, 32'h0, RESP_SLVERR);
      wr(16'h0001, 32'h0, RESP_SLVERR);
      $display("test reset done");
      wr(IDX_CTRL, 32'h02, RESP_OKAY);
      conv(1'b0, 1'b1, 12'habc);
      conv(1'b1, 1'b0, 12'h000);
      chk({16'h0, prev}, 32'h0abc);
      rd(IDX_PREV_HI, 32'h0a, RESP_OKAY);
      rd(IDX_PREV_LO, 32'hbc, RESP_OKAY);
      wr(IDX_CTRL, 32'h00, RESP_OKAY);
      conv(1'b0, 1'b1, 12'h123);
      // Start and done together: capture must see the older sample
      conv(1'b1, 1'b1, 12'h456);
      rd(IDX_PREV, 32'h1230, RESP_OKAY);
      conv(1'b1, 1'b0, 12'h000);
      rd(IDX_PREV, 32'h4560, RESP_OKAY);
      rd(IDX_SAMPLE, 32'h4560, RESP_OKAY);
      $display("test sample done");
      wr(IDX_ACC, 32'h0002_0000, RESP_OKAY);
      rd(IDX_ACC, 32'h00fe_0000, RESP_OKAY);
      wr(IDX_CTRL, 32'h21, RESP_OKAY);
      chk({16'h0, fltr}, 32'h8000);
      conv(1'b1, 1'b0, 12'h000);
      rd(IDX_PREV, 32'h8000, RESP_OKAY);
      lpf_value <= 16'h5a5a;
      wr(IDX_CTRL, 32'h05, RESP_OKAY);
      conv(1'b1, 1'b0, 12'h000);
      rd(IDX_PREV, 32'h5a5a, RESP_OKAY);
      rd(IDX_FILTER, 32'h5a5a, RESP_OKAY);
      conv(1'b0, 1'b1, 12'h111);
      rd(IDX_ACC, 32'h00fe_0000, RESP_OKAY);
      $display("test filter done");
      print_verdict();
   end
endmodule : tb_adc_previous_result_capture
`default_nettype wire
